/* File: design/protection_stage.sv */
// protection stage with pick-up, blocking, operate-time delay and axi4-lite registers
//
// Added by the designer: the register offsets and the AXI4-Lite register port.
`timescale 1ns/1ps
module protection_stage import prot_stage_pkg::*; #(
  parameter int unsigned tick_cycles = TICK_CYC,
  parameter int MEAS_W = 16,
  parameter logic [15:0] curve_a_tab [16] = '{default: 16'h0400}
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic [MEAS_W-1:0] meas_mag,
  input wire logic block_in,
  output logic start,
  output logic trip,
  output logic blocked,
  output logic event_valid,
  output logic irq,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  // settings
  logic [31:0] ctrl_r;
  logic [15:0] pickup_r, const_a_r, const_b_r;
  logic [18:0] fixed_delay_r;
  logic [11:0] time_dial_r;
  logic [2:0] int_status_r, int_mask_r;
  // stage state
  stage_state_t state_r;
  logic pick_r, start_r, trip_r, blocked_r, block_s_r, evt_r;
  logic [18:0] elapsed_r;
  logic [47:0] acc_r;
  logic [MEAS_W-1:0] start_meas_r, evt_meas_r;
  logic [31:0] tick_cnt_r, stamp_r, evt_time_r;
  // bus state
  logic aw_have_r, w_have_r, bvalid_r, rvalid_r;
  logic [7:0] waddr_r;
  logic [31:0] wdata_r, rdata_r;
  logic [3:0] wstrb_r;
  logic [1:0] bresp_r, rresp_r;
  // combinational helpers
  logic tick_c, above_c, below_c, pick_c, inverse_c, instant_c, done_c;
  logic blk_enter_c, start_ev_c, trip_ev_c, wr_go_c;
  logic [18:0] elapsed_nxt;
  logic [47:0] acc_nxt, inv_limit_c;
  logic [15:0] curve_a_c;
  logic [2:0] curve_sel_c, irq_set_c, irq_clr_c;

  // merge the write data into a register through the byte strobes
  function automatic logic [31:0] merge_w(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] be);
    logic [31:0] m;
    m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    return (old & ~m) | (nw & m);
  endfunction

  // program cycle tick
  always_ff @(posedge clk) begin
    if (reset || tick_c) begin
      tick_cnt_r <= 32'h0;
    end else begin
      tick_cnt_r <= tick_cnt_r + 32'h1;
    end
  end
  assign tick_c = (tick_cnt_r == 32'(tick_cycles - 1));

  // free running time stamp in program cycles
  always_ff @(posedge clk) begin
    if (reset) begin
      stamp_r <= 32'h0;
    end else if (tick_c) begin
      stamp_r <= stamp_r + 32'h1;
    end
  end

  // ratio test: release below 97 % of pick-up
  always_comb begin
    above_c = meas_mag > pickup_r;
    below_c = (32'(meas_mag) * 32'(FULL_PCT)) < (32'(pickup_r) * 32'(RESET_PCT));
    pick_c = pick_r ? !below_c : above_c;
  end

  // delay type: series applies only in inverse mode
  always_comb begin
    inverse_c = ctrl_r[DELAY_TYPE_BIT];
    curve_sel_c = ctrl_r[CURVE_LSB +: 3];
    if ((!ctrl_r[SERIES_BIT] && curve_sel_c == IEC_PARAM_SEL) ||
        (ctrl_r[SERIES_BIT] && curve_sel_c == IEEE_PARAM_SEL)) begin
      curve_a_c = const_a_r;
    end else begin
      curve_a_c = curve_a_tab[{ctrl_r[SERIES_BIT], curve_sel_c}];
    end
    // time dial scales the inverse operate limit
    inv_limit_c = 48'(curve_a_c) * 48'(time_dial_r) * 48'(pickup_r);
  end

  // zero fixed delay in fixed mode is instant
  assign instant_c = !inverse_c && (fixed_delay_r == 19'h0);

  // timer advance and completion
  always_comb begin
    elapsed_nxt = (elapsed_r == '1) ? elapsed_r : elapsed_r + 19'h1;
    // inverse: only excess above pick-up integrates, the hysteresis band adds nothing
    acc_nxt = above_c ? acc_r + 48'(meas_mag - pickup_r) * 48'(FULL_PCT) : acc_r;
    if (inverse_c) begin
      // fixed delay is a floor in inverse mode
      done_c = (acc_nxt >= inv_limit_c) && (elapsed_nxt >= fixed_delay_r);
    end else begin
      // fixed delay in 5 ms steps
      done_c = elapsed_nxt >= fixed_delay_r;
    end
  end

  // events seen at a program cycle edge
  assign blk_enter_c = tick_c && pick_c && block_in && (state_r != ST_BLOCKED);
  assign start_ev_c = tick_c && pick_c && !block_in && (state_r == ST_IDLE || state_r == ST_BLOCKED);
  assign trip_ev_c = tick_c && pick_c && !block_in &&
    (((state_r == ST_IDLE || state_r == ST_BLOCKED) && instant_c) || ((state_r == ST_RUN) && done_c));

  // blocking sampled once per program cycle; source gives one cycle lead
  always_ff @(posedge clk) begin
    if (reset) begin
      block_s_r <= 1'b0;
      pick_r <= 1'b0;
    end else if (tick_c) begin
      block_s_r <= block_in;
      pick_r <= pick_c;
    end
  end

  // stage state machine, evaluated once per program cycle
  always_ff @(posedge clk) begin
    if (reset) begin
      state_r <= ST_IDLE;
      start_r <= 1'b0;
      trip_r <= 1'b0;
      blocked_r <= 1'b0;
      elapsed_r <= '0;
      acc_r <= '0;
    end else if (tick_c) begin
      if (!pick_c) begin
        // release clears count, start and trip
        state_r <= ST_IDLE;
        start_r <= 1'b0;
        trip_r <= 1'b0;
        blocked_r <= 1'b0;
        elapsed_r <= '0;
        acc_r <= '0;
      end else if (block_in) begin
        state_r <= ST_BLOCKED;
        start_r <= 1'b0;
        trip_r <= 1'b0;
        blocked_r <= 1'b1;
        elapsed_r <= '0;
        acc_r <= '0;
      end else begin
        case (state_r)
          ST_IDLE, ST_BLOCKED: begin
            // start and begin timing; instant trips with start
            start_r <= 1'b1;
            blocked_r <= 1'b0;
            elapsed_r <= '0;
            acc_r <= '0;
            trip_r <= instant_c;
            state_r <= instant_c ? ST_TRIP : ST_RUN;
          end
          ST_RUN: begin
            elapsed_r <= elapsed_nxt;
            acc_r <= acc_nxt;
            if (done_c) begin
              trip_r <= 1'b1;
              state_r <= ST_TRIP;
            end
          end
          default: begin
            state_r <= ST_TRIP;
          end
        endcase
      end
    end
  end

  // blocking event record: time, start-up value, fault type
  always_ff @(posedge clk) begin
    if (reset) begin
      evt_r <= 1'b0;
      evt_time_r <= 32'h0;
      evt_meas_r <= '0;
      start_meas_r <= '0;
    end else begin
      evt_r <= blk_enter_c;
      if (tick_c && state_r == ST_IDLE && pick_c) begin
        start_meas_r <= meas_mag;
      end
      if (blk_enter_c) begin
        evt_time_r <= stamp_r;
        evt_meas_r <= (state_r == ST_IDLE) ? meas_mag : start_meas_r;
      end
    end
  end

  // interrupt status: hardware set wins over write-one clear
  always_comb begin
    irq_set_c = '0;
    irq_set_c[IRQ_START_BIT] = start_ev_c;
    irq_set_c[IRQ_TRIP_BIT] = trip_ev_c;
    irq_set_c[IRQ_BLOCK_BIT] = blk_enter_c;
    irq_clr_c = (wr_go_c && waddr_r == INT_STATUS_OFS && wstrb_r[0]) ? wdata_r[2:0] : 3'h0;
  end
  always_ff @(posedge clk) begin
    if (reset) begin
      int_status_r <= '0;
    end else begin
      int_status_r <= (int_status_r & ~irq_clr_c) | irq_set_c;
    end
  end

  // axi write address and data, taken in either order
  assign wr_go_c = aw_have_r && w_have_r && !bvalid_r;
  always_ff @(posedge clk) begin
    if (reset) begin
      aw_have_r <= 1'b0;
      w_have_r <= 1'b0;
      waddr_r <= 8'h0;
      wdata_r <= 32'h0;
      wstrb_r <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_r <= 1'b1;
        waddr_r <= s_axi_awaddr;
      end else if (wr_go_c) begin
        aw_have_r <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_r <= 1'b1;
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
      end else if (wr_go_c) begin
        w_have_r <= 1'b0;
      end
    end
  end

  // register writes and write response
  always_ff @(posedge clk) begin
    if (reset) begin
      ctrl_r <= CTRL_RST;
      pickup_r <= PICKUP_RST;
      fixed_delay_r <= FIXED_DELAY_RST;
      time_dial_r <= TIME_DIAL_RST;
      const_a_r <= CONST_A_RST;
      const_b_r <= CONST_B_RST;
      int_mask_r <= INT_MASK_RST;
      bvalid_r <= 1'b0;
      bresp_r <= RESP_OKAY;
    end else begin
      if (s_axi_bvalid && s_axi_bready) begin
        bvalid_r <= 1'b0;
      end
      if (wr_go_c) begin
        bvalid_r <= 1'b1;
        bresp_r <= RESP_OKAY;
        if (waddr_r == CTRL_OFS) begin
          ctrl_r <= merge_w(ctrl_r, wdata_r, wstrb_r) & 32'h0000_0073;
        end else if (waddr_r == PICKUP_OFS) begin
          pickup_r <= 16'(merge_w(32'(pickup_r), wdata_r, wstrb_r));
        end else if (waddr_r == FIXED_DELAY_OFS) begin
          fixed_delay_r <= 19'(merge_w(32'(fixed_delay_r), wdata_r, wstrb_r));
        end else if (waddr_r == TIME_DIAL_OFS) begin
          time_dial_r <= 12'(merge_w(32'(time_dial_r), wdata_r, wstrb_r));
        end else if (waddr_r == CONST_A_OFS) begin
          const_a_r <= 16'(merge_w(32'(const_a_r), wdata_r, wstrb_r));
        end else if (waddr_r == CONST_B_OFS) begin
          const_b_r <= 16'(merge_w(32'(const_b_r), wdata_r, wstrb_r));
        end else if (waddr_r == INT_MASK_OFS) begin
          int_mask_r <= 3'(merge_w(32'(int_mask_r), wdata_r, wstrb_r));
        end else if (waddr_r == INT_STATUS_OFS || waddr_r == STATUS_OFS || waddr_r == EVT_TIME_OFS ||
                     waddr_r == EVT_INFO_OFS || waddr_r == TIMESTAMP_OFS) begin
          bresp_r <= RESP_OKAY;
        end else begin
          bresp_r <= RESP_SLVERR;
        end
      end
    end
  end

  // register reads
  always_ff @(posedge clk) begin
    if (reset) begin
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0;
      rresp_r <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_r <= 1'b1;
      rresp_r <= RESP_OKAY;
      if (s_axi_araddr == CTRL_OFS) begin
        rdata_r <= ctrl_r;
      end else if (s_axi_araddr == PICKUP_OFS) begin
        rdata_r <= 32'(pickup_r);
      end else if (s_axi_araddr == FIXED_DELAY_OFS) begin
        rdata_r <= 32'(fixed_delay_r);
      end else if (s_axi_araddr == TIME_DIAL_OFS) begin
        rdata_r <= 32'(time_dial_r);
      end else if (s_axi_araddr == CONST_A_OFS) begin
        rdata_r <= 32'(const_a_r);
      end else if (s_axi_araddr == CONST_B_OFS) begin
        rdata_r <= 32'(const_b_r);
      end else if (s_axi_araddr == STATUS_OFS) begin
        rdata_r <= {24'h0, block_s_r, pick_r, state_r, 1'b0, blocked_r, trip_r, start_r};
      end else if (s_axi_araddr == INT_STATUS_OFS) begin
        rdata_r <= 32'(int_status_r);
      end else if (s_axi_araddr == INT_MASK_OFS) begin
        rdata_r <= 32'(int_mask_r);
      end else if (s_axi_araddr == EVT_TIME_OFS) begin
        rdata_r <= evt_time_r;
      end else if (s_axi_araddr == EVT_INFO_OFS) begin
        rdata_r <= {FAULT_OVER, 8'h0, 16'(evt_meas_r)};
      end else if (s_axi_araddr == TIMESTAMP_OFS) begin
        rdata_r <= stamp_r;
      end else begin
        rdata_r <= 32'h0;
        rresp_r <= RESP_SLVERR;
      end
    end else if (s_axi_rready) begin
      rvalid_r <= 1'b0;
    end
  end

  // port drives
  assign s_axi_awready = !aw_have_r;
  assign s_axi_wready = !w_have_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_arready = !rvalid_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;
  assign start = start_r;
  assign trip = trip_r;
  assign blocked = blocked_r;
  assign event_valid = evt_r;
  assign irq = |(int_status_r & int_mask_r);

  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  sequence tick_pick_free_s;
    tick_c && pick_c && !block_in;
  endsequence
  sequence tick_pick_blk_s;
    tick_c && pick_c && block_in;
  endsequence

  pickup_set_a: assert property (tick_c && above_c |=> pick_r)
    else $error("pick-up did not activate above level");
  hysteresis_hold_a: assert property (tick_c && pick_r && !below_c |=> pick_r)
    else $error("pick-up released inside hysteresis band");
  block_sample_a: assert property (tick_c |=> block_s_r == $past(block_in))
    else $error("blocking not sampled at program cycle");
  start_raise_a: assert property (tick_pick_free_s ##0 (state_r == ST_IDLE) |=> start_r)
    else $error("start missing after free pick-up");
  blocked_flag_a: assert property (tick_pick_blk_s |=> blocked_r && !start_r && !trip_r)
    else $error("blocked pick-up not indicated");
  block_clear_a: assert property (tick_c && block_in && start_r |=> !start_r && elapsed_r == 0)
    else $error("blocking left start active");
  block_event_a: assert property (blk_enter_c |=> event_valid && evt_time_r == $past(stamp_r))
    else $error("blocking event not recorded");
  instant_trip_a: assert property (tick_pick_free_s ##0 (state_r == ST_IDLE && instant_c)
    |=> trip_r && start_r)
    else $error("instant trip not with start");
  fixed_wait_a: assert property (tick_c && state_r == ST_RUN && !inverse_c && pick_c && !block_in &&
    elapsed_nxt < fixed_delay_r |=> !trip_r)
    else $error("fixed delay tripped early");
  min_time_a: assert property ($rose(trip_r) && inverse_c && !$past(instant_c)
    |-> $past(elapsed_nxt) >= fixed_delay_r)
    else $error("inverse trip before minimum time");
  release_clear_a: assert property (tick_c && !pick_c |=> !start_r && !trip_r && elapsed_r == 0)
    else $error("release did not clear timing");
  trip_start_a: assert property (trip_r |-> start_r)
    else $error("trip without start");
endmodule

/* File: design/prot_stage_pkg.sv */
// constants, register map and state type for the protection stage
// Operation
// - Pick-up activates when measured magnitude exceeds the set pick-up level.
// - Active pick-up releases only below 97 % of the pick-up level.
// - Blocking input is sampled at the start of every program cycle.
// - Pick-up without blocking raises start and begins operate-time evaluation.
// - Pick-up with blocking raises blocked and does no start or trip.
// - Blocking clears an active start and releases timing like pick-up dropout.
// - Every blocking records a time-stamped event with start-up value and fault type.
// - Instant operation trips in the same cycle as start.
// - Definite-time trips after the fixed delay while pick-up stays active.
// - Inverse-time trips after a delay from measured value versus pick-up level.
// - In inverse mode the fixed delay is a minimum; zero disables it.
// - Delay type selects definite or inverse counting, definite by default.
// - Fixed delay counts in 5 ms steps, default 40 ms.
// - Fixed delay of zero trips instantly; nonzero gives delayed operation. The code trips instantly on zero in definite mode only.
// - Curve series selects IEC or IEEE families, IEC default, inverse only.
// - IEC offers normal, extremely, very, long-time inverse and parameterised curves.
// - Time dial in 0.01 s steps, default 0.05, scales the inverse delay.
package prot_stage_pkg;
  // timing: one program cycle equals one delay step
  localparam int unsigned CLK_MHZ = 50;
  localparam int unsigned DELAY_STEP_US = 5000;
  localparam int unsigned TICK_CYC = DELAY_STEP_US * CLK_MHZ;
  localparam int unsigned BLOCK_LEAD_US = 5000;
  localparam int unsigned RESET_PCT = 97;
  localparam int unsigned FULL_PCT = 100;
  // register byte offsets
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] PICKUP_OFS = 8'h04;
  localparam logic [7:0] FIXED_DELAY_OFS = 8'h08;
  localparam logic [7:0] TIME_DIAL_OFS = 8'h0c;
  localparam logic [7:0] CONST_A_OFS = 8'h10;
  localparam logic [7:0] CONST_B_OFS = 8'h14;
  localparam logic [7:0] STATUS_OFS = 8'h18;
  localparam logic [7:0] INT_STATUS_OFS = 8'h1c;
  localparam logic [7:0] INT_MASK_OFS = 8'h20;
  localparam logic [7:0] EVT_TIME_OFS = 8'h24;
  localparam logic [7:0] EVT_INFO_OFS = 8'h28;
  localparam logic [7:0] TIMESTAMP_OFS = 8'h2c;
  // control field positions
  localparam int DELAY_TYPE_BIT = 0;
  localparam int SERIES_BIT = 1;
  localparam int CURVE_LSB = 4;
  localparam logic [2:0] IEC_PARAM_SEL = 3'h4;
  localparam logic [2:0] IEEE_PARAM_SEL = 3'h7;
  // interrupt bit positions
  localparam int IRQ_START_BIT = 0;
  localparam int IRQ_TRIP_BIT = 1;
  localparam int IRQ_BLOCK_BIT = 2;
  // reset values
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [15:0] PICKUP_RST = 16'h0100;
  localparam logic [18:0] FIXED_DELAY_RST = 19'h00008;
  localparam logic [11:0] TIME_DIAL_RST = 12'h005;
  localparam logic [15:0] CONST_A_RST = 16'h035c;
  localparam logic [15:0] CONST_B_RST = 16'h073a;
  localparam logic [2:0] INT_MASK_RST = 3'h0;
  localparam logic [7:0] FAULT_OVER = 8'h01;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  // stage states, gray along idle, run, trip
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_RUN = 2'b01,
    ST_TRIP = 2'b11,
    ST_BLOCKED = 2'b10
  } stage_state_t;
endpackage

/* File: testbench/meas_source.sv */
// measurement path and blocking matrix model feeding the stage
`timescale 1ns/1ps
module meas_source (
  input wire logic clk,
  input wire logic [15:0] want_mag,
  input wire logic want_block,
  output logic [15:0] meas_mag,
  output logic block_in
);
  // sample and matrix output follow a command one clock later
  always @(posedge clk) begin
    meas_mag <= want_mag;
    block_in <= want_block;
  end
endmodule

/* File: testbench/tb.sv */
// self-checking bench for the protection stage
`timescale 1ns/1ps
module tb import prot_stage_pkg::*;;
  localparam int T = 4;
  typedef struct packed {logic [15:0] m; logic b; logic [2:0] e;} row_t;
  typedef struct packed {logic [31:0] c; logic [15:0] m; int n;} dly_t;
  // level cases: magnitude, blocking, then expected start, trip, blocked
  localparam row_t ROWS [8] = '{'{16'd256, 1'b0, 3'b000}, '{16'd257, 1'b0, 3'b110}, '{16'd249, 1'b0, 3'b110},
    '{16'd248, 1'b0, 3'b000}, '{16'd300, 1'b1, 3'b001}, '{16'd300, 1'b0, 3'b110}, '{16'd300, 1'b1, 3'b001},
    '{16'd0, 1'b0, 3'b000}};
  // delay cases: control word, magnitude, clocks from start to trip
  localparam dly_t DLY [5] = '{'{32'h0, 16'd257, 6 * T}, '{32'h2, 16'd257, 6 * T}, '{32'h0, 16'hffff, 6 * T},
    '{32'h1, 16'hffff, 6 * T}, '{32'h1, 16'd257, -1}};
  localparam logic [7:0] RA [7] = '{CTRL_OFS, PICKUP_OFS, FIXED_DELAY_OFS, TIME_DIAL_OFS, CONST_A_OFS,
    CONST_B_OFS, INT_MASK_OFS};
  localparam logic [31:0] RV [7] = '{CTRL_RST, 32'(PICKUP_RST), 32'(FIXED_DELAY_RST), 32'(TIME_DIAL_RST),
    32'(CONST_A_RST), 32'(CONST_B_RST), 32'(INT_MASK_RST)};
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic [15:0] want_mag = '0;
  logic want_block = 1'b0;
  logic [15:0] meas_mag;
  logic block_in, start, trip, blocked, event_valid, irq;
  logic [7:0] awaddr = '0, araddr = '0;
  logic [31:0] wdata = '0, rdata;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  int mismatches = 0, checks = 0, n_evt = 0;

  meas_source i_src (.clk(clk), .want_mag(want_mag), .want_block(want_block), .meas_mag(meas_mag),
    .block_in(block_in));
  protection_stage #(.tick_cycles(T)) i_dut (.clk(clk), .reset(reset), .meas_mag(meas_mag), .block_in(block_in),
    .start(start), .trip(trip), .blocked(blocked), .event_valid(event_valid), .irq(irq), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));

  // 50 MHz clock
  initial begin
    forever #10 clk = ~clk;
  end
  // count blocking event pulses
  always @(posedge clk) begin
    if (event_valid === 1'b1) n_evt <= n_evt + 1;
  end

  // verdict and end of run
  task automatic complete_run();
    if (mismatches == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // value comparison
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  // a bounded wait ran out
  task automatic timed_out(input string what);
    mismatches++;
    $display("BAD %s expected 1 seen timeout", what);
    complete_run();
  endtask
  task automatic ticks(input int n);
    repeat (n * T) @(posedge clk);
  endtask
  // axi4-lite write, address and data offered together
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int k;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (k = 0; k < 50; k++) begin
      @(posedge clk);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
      if (bvalid === 1'b1) break;
    end
    if (k == 50) timed_out("bvalid");
    bready <= 1'b0;
    check("bresp", 32'(er), 32'(bresp));
    @(posedge clk);
  endtask
  // axi4-lite read
  task automatic axi_read(input logic [7:0] a, input logic [1:0] er, output logic [31:0] d);
    int k;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (k = 0; k < 50; k++) begin
      @(posedge clk);
      if (arready === 1'b1) arvalid <= 1'b0;
      if (rvalid === 1'b1) break;
    end
    if (k == 50) timed_out("rvalid");
    d = rdata;
    rready <= 1'b0;
    check("rresp", 32'(er), 32'(rresp));
    @(posedge clk);
  endtask
  // bounded wait for the start output
  task automatic wait_start();
    int k;
    for (k = 0; k < 5 * T && start !== 1'b1; k++) @(posedge clk);
    if (k == 5 * T) timed_out("start");
  endtask
  // from rest, apply a magnitude and count clocks from start to trip, -1 if none
  task automatic op_time(input logic [15:0] m, output int n);
    want_mag <= '0;
    ticks(3);
    want_mag <= m;
    wait_start();
    for (n = 0; n < 30 * T && trip !== 1'b1; n++) @(posedge clk);
    if (n == 30 * T) n = -1;
  endtask

  // main sequence
  initial begin
    logic [31:0] d;
    int n;
    int n0;
    repeat (16) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    foreach (RA[i]) begin
      axi_read(RA[i], RESP_OKAY, d);
      check("reset value", RV[i], d);
    end
    axi_read(8'h40, RESP_SLVERR, d);
    check("unmapped read", 32'h0, d);
    axi_write(8'h40, 32'hffff_ffff, RESP_SLVERR);
    axi_write(STATUS_OFS, 32'hff, RESP_OKAY);
    // instant operation for the level table
    axi_write(FIXED_DELAY_OFS, 32'h0, RESP_OKAY);
    n0 = n_evt;
    foreach (ROWS[i]) begin
      want_mag <= ROWS[i].m;
      want_block <= ROWS[i].b;
      ticks(3);
      check("start trip blocked", 32'(ROWS[i].e), 32'({start, trip, blocked}));
    end
    check("event pulses", 32'd2, 32'(n_evt - n0));
    axi_read(EVT_INFO_OFS, RESP_OKAY, d);
    check("event info", {FAULT_OVER, 24'h00_012c}, d & 32'hff00_ffff);
    // sticky status, mask and write-one-to-clear
    axi_read(INT_STATUS_OFS, RESP_OKAY, d);
    check("int status", 32'h7, d);
    check("irq masked", 32'h0, 32'(irq));
    axi_write(INT_MASK_OFS, 32'h4, RESP_OKAY);
    check("irq", 32'h1, 32'(irq));
    axi_write(INT_STATUS_OFS, 32'h4, RESP_OKAY);
    check("irq cleared", 32'h0, 32'(irq));
    axi_read(INT_STATUS_OFS, RESP_OKAY, d);
    check("int status", 32'h3, d);
    // delay types and minimum time over a fixed delay of six steps
    axi_write(FIXED_DELAY_OFS, 32'd6, RESP_OKAY);
    foreach (DLY[i]) begin
      axi_write(CTRL_OFS, DLY[i].c, RESP_OKAY);
      op_time(DLY[i].m, n);
      check("operate time", 32'(DLY[i].n), 32'(n));
    end
    // release before the delay runs out, then a fresh full delay
    axi_write(CTRL_OFS, 32'h0, RESP_OKAY);
    want_mag <= '0;
    ticks(3);
    want_mag <= 16'd300;
    ticks(3);
    want_mag <= '0;
    ticks(2);
    check("early release", 32'h0, 32'({start, trip}));
    op_time(16'd300, n);
    check("restarted delay", 32'(6 * T), 32'(n));
    // a blocking pulse between program cycles goes unseen
    want_mag <= '0;
    ticks(3);
    want_mag <= 16'd300;
    wait_start();
    want_block <= 1'b1;
    @(posedge clk);
    want_block <= 1'b0;
    ticks(2);
    check("glitch ignored", 32'h4, 32'({start, trip, blocked}));
    // blocking presented well ahead of the delay expiry
    want_block <= 1'b1;
    ticks(6);
    check("blocked in run", 32'h1, 32'({start, trip, blocked}));
    check("irq block", 32'h1, 32'(irq));
    axi_read(STATUS_OFS, RESP_OKAY, d);
    check("status", 32'h0000_00e4, d);
    // reset while blocked clears outputs and restores default settings
    reset <= 1'b1;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    check("outputs after reset", 32'h0, 32'({start, trip, blocked, event_valid, irq}));
    axi_read(FIXED_DELAY_OFS, RESP_OKAY, d);
    check("delay after reset", 32'(FIXED_DELAY_RST), d);
    want_block <= 1'b0;
    want_mag <= '0;
    ticks(3);
    complete_run();
  end
endmodule
